// File: design/slcc_pkg.sv
// Functional notes
// - twisted pair runs sync path at 20 kbit/s; modem mode follows modem clock; code cells are 48us, about 20.8 kbit/s
// - divide 960kHz by 48 for encoder clock and sync transmit clock; code divides a 1MHz tick (20MHz / 20) by 48
// - async divider gives 19200Hz and 9600Hz outputs; code gives 20kHz and 10kHz from its 1MHz tick
// - mux picks one async rate; drives both async transmit and receive clocks
// - async adapter divides picked clock by 16 or 64: four rates
// - encoder turns clock-aligned data into dc-free transition-rich stream
// - receive clock from loadable down counter plus divider, nominally encoder rate
// - down counter reloads preset on carry then keeps decrementing
// - stream transition pulse reloads counter and resets divider to lock
// - decoder outputs high for encoded ones, low for zeros; clock at 20kHz; code about 20.8kHz (48us cells)
// - constant one gives 100us square wave; constant zero halves period; code gives 96us and 48us
// - diagnostic mode loops encoder output into decoder instead of receiver
// - read/write high reads, low writes; with register select picks register
// - async adapter data lines undriven unless addressed
// - adapter interrupts active low, open-collector for wire-OR
// - active-low host reset clears sync transmit and receive sections
// - sync adapter responds only while its select is low
// - sync adapter shifts tx on transmit clock, samples rx on receive clock
// - self-test pulses modem and dialler outputs about once per second
// - terminal-ready button held in self-test holds DTR low; modem control pulses continue
// - diagnostic mode after power-up feeds encoder a continuous one
`default_nettype none
package slcc_pkg;
   localparam int unsigned CLK_HZ      = 20_000_000;
   localparam int unsigned SYS_HZ      = 960_000;
   // system tick every 20 clocks of the 20MHz clock (1MHz, SYS_DIV rounds 20.8 down)
   localparam int unsigned SYS_DIV     = CLK_HZ / SYS_HZ;
   localparam logic [4:0]  SYS_DIV_M1  = 5'(SYS_DIV - 1);
   localparam int unsigned ENC_DIV     = 48;
   localparam logic [5:0]  ENC_DIV_M1  = 6'(ENC_DIV - 1);
   // receive: down counter 0..11, divider by 4 -> 48 ticks per cell
   localparam logic [3:0]  RX_PRESET   = 4'hB;
   localparam logic [1:0]  RX_DIV_M1   = 2'h3;
   localparam logic [5:0]  ASYNC_HI_M1 = 6'(SYS_HZ / 19200 - 1);
   localparam logic [6:0]  ASYNC_LO_M1 = 7'(SYS_HZ / 9600 - 1);
   localparam logic [19:0] SEC_TICKS   = 20'hF423F;
   localparam logic [1:0]  REG_COUNT   = 2'h2;
   typedef enum logic [1:0] {SLCC_TWISTED, SLCC_MODEM,
                             SLCC_DIAG, SLCC_SELFTEST} slcc_mode_e;
endpackage : slcc_pkg
`default_nettype wire

// File: design/slcc_rx_recover.sv
`default_nettype none
module slcc_rx_recover (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic sys_tick,
   input  wire logic line_in,
   output logic      rx_clk_out,
   output logic      rx_bit_stb,
   output logic      rx_data
);
   logic [3:0] dcnt, next_dcnt;
   logic [1:0] div, next_div;
   logic       prev_in, next_prev_in;
   logic       sync_pulse;
   logic       next_rx_data;
   logic       mid_ok, next_mid_ok;
   logic       mid_seen, next_mid_seen;

   assign sync_pulse = sys_tick && (line_in != prev_in) && !mid_ok;

   always_comb begin
      next_dcnt    = dcnt;
      next_div     = div;
      next_prev_in = prev_in;
      next_rx_data = rx_data;
      next_mid_ok  = mid_ok;
      rx_bit_stb   = 1'b0;
      if (sys_tick) begin
         next_prev_in = line_in;
         if (sync_pulse) begin
            next_dcnt   = slcc_pkg::RX_PRESET;
            next_div    = '0;
            next_mid_ok = 1'b1;
         end else if (dcnt == 4'h0) begin
            next_dcnt = slcc_pkg::RX_PRESET;
            next_div  = div + 2'h1;
            if (div == 2'h2) begin
               // mid window shut: an edge inside it marks a zero
               next_rx_data = !mid_seen;
               rx_bit_stb   = 1'b1;
               next_mid_ok  = 1'b0;
            end
         end else begin
            next_dcnt = dcnt - 4'h1;
         end
      end
   end

   // edge inside the mid window marks a zero
   always_comb begin
      next_mid_seen = mid_seen;
      if (sys_tick) begin
         if (sync_pulse)
            next_mid_seen = 1'b0;
         else if ((line_in != prev_in) && mid_ok)
            next_mid_seen = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         dcnt     <= slcc_pkg::RX_PRESET;
         div      <= '0;
         prev_in  <= 1'b0;
         rx_data  <= 1'b1;
         mid_ok   <= 1'b0;
         mid_seen <= 1'b0;
      end else begin
         dcnt     <= next_dcnt;
         div      <= next_div;
         prev_in  <= next_prev_in;
         rx_data  <= next_rx_data;
         mid_ok   <= next_mid_ok;
         mid_seen <= next_mid_seen;
      end
   end

   assign rx_clk_out = div[1];

   a_rx_reload: assert property (@(posedge clk) disable iff (rst)
      sync_pulse |=> dcnt == slcc_pkg::RX_PRESET && div == 2'h0)
      else $error("counter not reloaded on sync");
endmodule // slcc_rx_recover
`default_nettype wire

// File: design/slcc_codec.sv
`default_nettype none
module slcc_codec (
   input  wire logic                 clk,
   input  wire logic                 rst,
   input  wire slcc_pkg::slcc_mode_e mode,
   input  wire logic                 modem_tx_clk,
   input  wire logic                 modem_rx_clk,
   input  wire logic                 async_rate_sel,
   input  wire logic                 async_div64,
   input  wire logic                 tx_data,
   input  wire logic                 line_rx,
   input  wire logic                 dtr_button,
   input  wire logic                 cpu_reset_n,
   input  wire logic                 sync_sel_n,
   input  wire logic                 async_sel,
   input  wire logic                 cpu_rw,
   input  wire logic                 cpu_reg_sel,
   input  wire logic [7:0]           cpu_wdata,
   input  wire logic                 sync_irq_req,
   input  wire logic                 async_irq_req,
   output logic [7:0]                cpu_rdata,
   output logic                      cpu_data_oe,
   output logic                      sync_irq_n_oe,
   output logic                      async_irq_n_oe,
   output logic                      line_tx,
   output logic                      encoder_clk,
   output logic                      sync_tx_clk,
   output logic                      sync_rx_clk,
   output logic                      async_clk,
   output logic                      async_bit_stb,
   output logic                      sync_rx_data,
   output logic                      sync_rx_stb,
   output logic                      dtr,
   output logic                      modem_ctl_pulse
);
   ////////////////////////////////////////////////////////////////////
   logic [4:0]  sdiv, next_sdiv;
   logic        sys_tick;
   logic [5:0]  ediv, next_ediv;
   logic        enc_half;
   logic [5:0]  ahi, next_ahi;
   logic [6:0]  alo, next_alo;
   logic        clk19, next_clk19, clk96, next_clk96;
   logic [5:0]  apre, next_apre;
   logic        cur_bit, next_cur_bit, line, next_line;
   logic [19:0] sec, next_sec;
   logic        rec_clk, rec_stb, rec_data;
   logic        dec_in;
   logic [7:0]  sreg [slcc_pkg::REG_COUNT];
   logic [7:0]  next_sreg [slcc_pkg::REG_COUNT];
   logic        tx_sh, next_tx_sh, rx_sh, next_rx_sh;
   logic        enc_bit_stb;

   assign sys_tick = (sdiv == slcc_pkg::SYS_DIV_M1);
   assign enc_bit_stb = sys_tick && ediv == slcc_pkg::ENC_DIV_M1;
   assign enc_half = sys_tick && ediv == 6'(slcc_pkg::ENC_DIV / 2 - 1);

   always_comb begin
      next_sdiv  = sys_tick ? 5'h00 : sdiv + 5'h01;
      next_ediv  = ediv;
      next_ahi   = ahi;
      next_alo   = alo;
      next_clk19 = clk19;
      next_clk96 = clk96;
      next_sec   = sec;
      if (sys_tick) begin
         next_ediv = enc_bit_stb ? 6'h00 : ediv + 6'h01;
         if (ahi == slcc_pkg::ASYNC_HI_M1) begin
            next_ahi   = 6'h00;
            next_clk19 = 1'b1;
         end else begin
            next_ahi   = ahi + 6'h01;
            next_clk19 = 1'b0;
         end
         if (alo == slcc_pkg::ASYNC_LO_M1) begin
            next_alo   = 7'h00;
            next_clk96 = 1'b1;
         end else begin
            next_alo   = alo + 7'h01;
            next_clk96 = 1'b0;
         end
         next_sec = (sec == slcc_pkg::SEC_TICKS) ? 20'h0 : sec + 20'h1;
      end else begin
         next_clk19 = 1'b0;
         next_clk96 = 1'b0;
      end
   end

   // async picked rate, then by 16 or 64 inside the adapter
   assign async_clk = async_rate_sel ? clk19 : clk96;
   always_comb begin
      next_apre     = apre;
      async_bit_stb = 1'b0;
      if (async_clk) begin
         if (apre == (async_div64 ? 6'h3F : 6'h0F)) begin
            next_apre     = 6'h00;
            async_bit_stb = 1'b1;
         end else begin
            next_apre = apre + 6'h01;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // line encoder: biphase cells of 48 ticks, 48us at the 20MHz clock
   always_comb begin
      next_cur_bit = cur_bit;
      next_line    = line;
      if (enc_bit_stb) begin
         next_cur_bit = (mode == slcc_pkg::SLCC_DIAG) ? 1'b1 : tx_data;
         next_line    = !line;
      end else if (enc_half && !cur_bit) begin
         next_line = !line;
      end
   end
   assign line_tx     = line;
   assign encoder_clk = ediv < 6'(slcc_pkg::ENC_DIV / 2);
   assign sync_tx_clk = (mode == slcc_pkg::SLCC_MODEM) ? modem_tx_clk
                                                       : enc_bit_stb;
   assign dec_in = (mode == slcc_pkg::SLCC_DIAG) ? line : line_rx;

   slcc_rx_recover u_rx (
      .clk        (clk),
      .sys_tick   (sys_tick),
      .rst        (rst),
      .line_in    (dec_in),
      .rx_clk_out (rec_clk),
      .rx_bit_stb (rec_stb),
      .rx_data    (rec_data)
   );
   assign sync_rx_clk  = (mode == slcc_pkg::SLCC_MODEM) ? modem_rx_clk
                                                        : rec_stb;
   assign sync_rx_data = rec_data;
   assign sync_rx_stb  = rec_stb;

   ////////////////////////////////////////////////////////////////////
   // adapter shift stages and processor side
   always_comb begin
      next_tx_sh = tx_sh;
      next_rx_sh = rx_sh;
      for (int i = 0; i < 2; i++) next_sreg[i] = sreg[i];
      if (sync_tx_clk) next_tx_sh = tx_data;
      if (sync_rx_clk) next_rx_sh = rec_data;
      if (!sync_sel_n && !cpu_rw)
         next_sreg[cpu_reg_sel] = cpu_wdata;
      if (!cpu_reset_n) begin
         next_tx_sh = 1'b0;
         next_rx_sh = 1'b0;
      end
   end
   assign cpu_data_oe = cpu_rw && (!sync_sel_n || async_sel);
   assign cpu_rdata   = !sync_sel_n ? sreg[cpu_reg_sel] : 8'h00;
   assign sync_irq_n_oe  = sync_irq_req;
   assign async_irq_n_oe = async_irq_req;

   logic pulse_win;
   assign pulse_win = (mode == slcc_pkg::SLCC_SELFTEST) && sec < 20'h00010;
   assign modem_ctl_pulse = pulse_win;
   assign dtr = pulse_win && !dtr_button;

   always_ff @(posedge clk) begin
      if (rst) begin
         sdiv    <= '0;
         ediv    <= '0;
         ahi     <= '0;
         alo     <= '0;
         clk19   <= 1'b0;
         clk96   <= 1'b0;
         apre    <= '0;
         cur_bit <= 1'b1;
         line    <= 1'b0;
         sec     <= '0;
         tx_sh   <= 1'b0;
         rx_sh   <= 1'b0;
         sreg[0] <= 8'h00;
         sreg[1] <= 8'h00;
      end else begin
         sdiv    <= next_sdiv;
         ediv    <= next_ediv;
         ahi     <= next_ahi;
         alo     <= next_alo;
         clk19   <= next_clk19;
         clk96   <= next_clk96;
         apre    <= next_apre;
         cur_bit <= next_cur_bit;
         line    <= next_line;
         sec     <= next_sec;
         tx_sh   <= next_tx_sh;
         rx_sh   <= next_rx_sh;
         sreg[0] <= next_sreg[0];
         sreg[1] <= next_sreg[1];
      end
   end

   // clocks since the last cell start, for the cell-length check
   logic [9:0] cell_cnt, next_cell_cnt;
   logic       cell_seen, next_cell_seen;
   always_comb begin
      next_cell_cnt  = enc_bit_stb ? 10'h000 : cell_cnt + 10'h001;
      next_cell_seen = cell_seen || enc_bit_stb;
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         cell_cnt  <= '0;
         cell_seen <= 1'b0;
      end else begin
         cell_cnt  <= next_cell_cnt;
         cell_seen <= next_cell_seen;
      end
   end

   a_enc_period: assert property (@(posedge clk) disable iff (rst)
      enc_bit_stb && cell_seen |->
      cell_cnt == 10'(slcc_pkg::ENC_DIV * slcc_pkg::SYS_DIV - 1))
      else $error("encoder cell not 48 ticks");
   a_diag_loop: assert property (@(posedge clk) disable iff (rst)
      mode == slcc_pkg::SLCC_DIAG |-> dec_in == line)
      else $error("loopback not routed");
   a_dtr_held: assert property (@(posedge clk) disable iff (rst)
      dtr_button |-> !dtr)
      else $error("dtr pulsed while button held");
   a_bus_float: assert property (@(posedge clk) disable iff (rst)
      sync_sel_n && !async_sel |-> !cpu_data_oe)
      else $error("data driven unaddressed");
   a_one_edges: assert property (@(posedge clk) disable iff (rst)
      enc_half && cur_bit |=> $stable(line))
      else $error("mid edge for one");
   a_zero_edge: assert property (@(posedge clk) disable iff (rst)
      enc_half && !cur_bit |=> line != $past(line))
      else $error("no mid edge for zero");
   a_async_mux: assert property (@(posedge clk) disable iff (rst)
      async_rate_sel |-> async_clk == clk19)
      else $error("async mux wrong");
   a_sync_reset: assert property (@(posedge clk) disable iff (rst)
      !cpu_reset_n |=> !tx_sh && !rx_sh)
      else $error("sync sections not cleared");
   c_rx_bit: cover property (@(posedge clk) rec_stb);
   c_selftest: cover property (@(posedge clk) pulse_win);
   c_async: cover property (@(posedge clk) async_bit_stb);
   c_rec_clk: cover property (@(posedge clk) $rose(rec_clk));
endmodule // slcc_codec
`default_nettype wire

// File: sim/slcc_remote_unit.sv
`default_nettype none
module slcc_remote_unit #(
   parameter int CELL = 962
) (
   input  wire logic clk,
   input  wire logic data,
   output logic      cell_stb,
   output logic      line
);
   timeunit 1ns;
   timeprecision 1ps;
   int   cnt  = 0;
   logic bitv = 1'b1;
   initial line = 1'b0;
   // cell slightly off nominal so the receiver must track the far clock
   assign cell_stb = (cnt == CELL - 1);
   always @(posedge clk) begin
      cnt <= (cnt == CELL - 1) ? 0 : cnt + 1;
      if (cnt == CELL - 1) begin
         bitv <= data;
         line <= ~line;
      end else if (cnt == CELL / 2 - 1 && !bitv) begin
         line <= ~line;
      end
   end
endmodule // slcc_remote_unit
`default_nettype wire

// File: sim/serial_line_clock_codec_tb.sv
`default_nettype none
module serial_line_clock_codec_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, rst = 1, mtx = 0, mrx = 0, rsel = 1, d64 = 0;
   logic txd = 1, btn = 0, ssel_n = 1, asel = 0, rw = 0, rs = 0;
   logic sreq = 0, areq = 0, pdata = 1, p_stb, line, cap = 0;
   logic rs_q = 0, crst_n = 1;
   logic [7:0] regm [2] = '{8'h00, 8'h00};
   logic [7:0] wd = 8'h00, rd;
   slcc_pkg::slcc_mode_e mode = slcc_pkg::SLCC_TWISTED;
   logic oe, sioe, aioe, ltx, ecl, stc, src, acl, abs, srd, srs, dtr, mcp;
   logic enc_q = 0, tx_q = 0, as_q = 0, bs_q = 0;
   int errors = 0, tests_run = 0, cyc = 0;
   int g_enc, g_tx, g_as, g_bs, enc_gap, tx_gap, as_gap, bs_gap;
   int n_stx, n_srx, n_dtr, n_mcp, n_abs, best, m, j;
   logic sq[$], rq[$];
   always #25 clk = ~clk;
   slcc_remote_unit far (.clk(clk), .data(pdata), .cell_stb(p_stb),
                         .line(line));
   slcc_codec dut (.clk(clk), .rst(rst), .mode(mode), .modem_tx_clk(mtx),
      .modem_rx_clk(mrx), .async_rate_sel(rsel), .async_div64(d64),
      .tx_data(txd), .line_rx(line), .dtr_button(btn), .cpu_reset_n(crst_n),
      .sync_sel_n(ssel_n), .async_sel(asel), .cpu_rw(rw),
      .cpu_reg_sel(rs), .cpu_wdata(wd), .sync_irq_req(sreq),
      .async_irq_req(areq), .cpu_rdata(rd), .cpu_data_oe(oe),
      .sync_irq_n_oe(sioe), .async_irq_n_oe(aioe), .line_tx(ltx),
      .encoder_clk(ecl), .sync_tx_clk(stc), .sync_rx_clk(src),
      .async_clk(acl), .async_bit_stb(abs), .sync_rx_data(srd),
      .sync_rx_stb(srs), .dtr(dtr), .modem_ctl_pulse(mcp));
   ////////////////////////////////////////////////////////////////////
   task automatic finish_test();
      $display("errors=%0d tests_run=%0d", errors, tests_run);
      if (errors == 0 && tests_run > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic chk_bit(string n, logic e, logic g);
      tests_run++;
      if (g !== e) begin
         errors++;
         $display("ERROR %s expected %b seen %b", n, e, g);
      end
   endtask
   task automatic chk_num(string n, int e, int g);
      tests_run++;
      if (g != e) begin
         errors++;
         $display("ERROR %s expected %0d seen %0d", n, e, g);
      end
   endtask
   task automatic chk_byte(string n, logic [7:0] e, logic [7:0] g);
      tests_run++;
      if (g !== e) begin
         errors++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   ////////////////////////////////////////////////////////////////////
   // edge spacing and pulse counters, plus the hang limit
   always @(posedge clk) begin
      cyc++;
      if (cyc == 100000) begin
         errors++;
         finish_test();
      end
      g_enc++; g_tx++; g_as++; g_bs++;
      if (ecl === 1'b1 && !enc_q) begin enc_gap = g_enc; g_enc = 0; end
      if (ltx !== tx_q) begin tx_gap = g_tx; g_tx = 0; end
      if (acl === 1'b1 && !as_q) begin as_gap = g_as; g_as = 0; end
      if (abs === 1'b1 && !bs_q) begin bs_gap = g_bs; g_bs = 0; end
      n_stx += (stc === 1'b1); n_srx += (src === 1'b1);
      n_dtr += (dtr === 1'b1);
      n_mcp += (mcp === 1'b1);
      n_abs += (abs === 1'b1);
      enc_q = ecl; tx_q = ltx; as_q = acl; bs_q = abs;
      if (cap && p_stb) sq.push_back(pdata);
      // data follows its strobe by one clock; start at the first sent cell
      if (cap && rs_q && sq.size() > 0) rq.push_back(srd);
      rs_q = (srs === 1'b1);
   end
   always @(negedge clk) if (p_stb) pdata <= 1'($urandom);
   ////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(32'h9316));
      repeat (5) @(negedge clk);
      rst = 0;
      repeat (4000) @(negedge clk);
      n_stx = 0;
      repeat (9600) @(negedge clk);
      chk_num("encoder_clk period", 960, enc_gap);
      chk_num("sync_tx_clk count", 10, n_stx);
      chk_num("line_tx ones gap", 960, tx_gap);
      txd = 0;
      repeat (3000) @(negedge clk);
      chk_num("line_tx zeros gap", 480, tx_gap);
      cap = 1;
      repeat (19500) @(negedge clk);
      cap = 0;
      best = 0;
      for (int k = 0; k < 5; k++) begin
         m = 0;
         for (int i = 8; i < rq.size(); i++) begin
            j = i - k;
            if (j < sq.size() && rq[i] === sq[j]) m++;
         end
         if (m > best) best = m;
      end
      chk_num("decoded bits", rq.size() - 8, best);
      chk_bit("enough bits", 1'b1, rq.size() > 15);
      mode = slcc_pkg::SLCC_DIAG;
      txd = 1;
      repeat (6000) @(negedge clk);
      chk_bit("loopback data", 1'b1, srd);
      mode = slcc_pkg::SLCC_MODEM;
      n_stx = 0; n_srx = 0;
      crst_n = 0;
      @(negedge clk);
      crst_n = 1;
      repeat (5) begin
         mtx = 1; mrx = 1;
         @(negedge clk);
         mtx = 0; mrx = 0;
         repeat (20) @(negedge clk);
      end
      chk_num("modem tx strobes", 5, n_stx);
      chk_num("modem rx strobes", 5, n_srx);
      repeat (40) begin
         {asel, ssel_n, rw, rs, sreq, areq} = 6'($urandom);
         wd = 8'($urandom);
         @(negedge clk);
         @(negedge clk);
         chk_bit("cpu_data_oe", rw & (asel | ~ssel_n), oe);
         chk_bit("sync_irq_n_oe", sreq, sioe);
         chk_bit("async_irq_n_oe", areq, aioe);
         if (!ssel_n && !rw) regm[rs] = wd;
         chk_byte("cpu_rdata", ssel_n ? 8'h00 : regm[rs], rd);
      end
      rsel = 1;
      repeat (2000) @(negedge clk);
      chk_num("async_clk 19200", 1000, as_gap);
      chk_num("async bit /16", 16000, bs_gap);
      d64 = 1;
      n_abs = 0;
      repeat (20000) @(negedge clk);
      chk_num("async bit /64 quiet", 0, n_abs);
      rsel = 0;
      repeat (5000) @(negedge clk);
      chk_num("async_clk 9600", 2000, as_gap);
      mode = slcc_pkg::SLCC_SELFTEST;
      for (int b = 0; b < 2; b++) begin
         btn = (b == 0);
         rst = 1;
         repeat (5) @(negedge clk);
         rst = 0;
         n_dtr = 0;
         n_mcp = 0;
         repeat (400) @(negedge clk);
         chk_num("modem_ctl_pulse width", 320, n_mcp);
         chk_num("dtr pulse width", (b == 0) ? 0 : 320, n_dtr);
      end
      finish_test();
   end
endmodule // serial_line_clock_codec_tb
`default_nettype wire
